// ===== wdt_cpu_model.sv
// file: behavioural cpu core that issues watchdog clear and halt instructions
`timescale 1ns/1ps
`default_nettype none
module wdt_cpu_model (
	input wire logic clk,
	input wire logic cpu_hold,
	input wire logic serve,
	input wire logic want_halt,
	output logic clear_watchdog_instr,
	output logic halt_instr
);
	int gap = 0;
	////////////////////////////////////////////////////////////////
	// a held core fetches nothing, so no instruction leaves it then
	always @(posedge clk) begin
		clear_watchdog_instr <= 1'b0;
		halt_instr <= 1'b0;
		gap <= gap + 1;
		if (!cpu_hold && serve && gap >= 200) begin
			clear_watchdog_instr <= 1'b1;
			gap <= 0;
		end
		if (!cpu_hold && want_halt)
			halt_instr <= 1'b1;
	end
	initial begin
		clear_watchdog_instr = 1'b0;
		halt_instr = 1'b0;
	end
endmodule // wdt_cpu_model
`default_nettype wire

// ===== wdt_halt_reset.sv
// module: watchdog, halt/wake sequencing and reset-cause flags
// How it works
// - watchdog clock: rc oscillator or sysclk/4
// - disabled watchdog ignores all watchdog operations
// - eight-stage divide by 256 base counter
// - select bits 2:0 pick prescale 1..128
// - bit 3 and high nibble are user flags
// - overflow in run: full reset, timeout set
// - overflow in halt: warm reset only
// - pin reset outside the startup delay, clear or halt clears counter
// - single or paired clear instruction mode
// - halt stops system clock, state kept
// - halt sets powerdown, clears timeout; clear clears
// - wake on reset, irq, port fall, overflow
// - pin reset during halt does full init
// - interrupt wake: resume or take interrupt
// - port wake resumes after halt
// - crystal wake adds 1024 clocks; rc none
// - startup delay at power-up and crystal wake only
// - reset cause encoded in flags
// - chip reset: pc zero, ports input, etc
// - instruction-clock watchdog stops in halt
// - rc mode drives sysclk/4 on osc out
// - software writes never touch the two flags
// - timeout flag set/clear events
`timescale 1ns/1ps
`default_nettype none
module wdt_halt_reset #(
	parameter int wake_width = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reset_pin_n,
	input wire logic wdt_osc,
	input wire logic opt_wdt_enable,
	input wire logic opt_wdt_use_rc,
	input wire logic opt_two_clear,
	input wire logic opt_crystal,
	input wire logic [wake_width-1:0] opt_wake_enable,
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic clear_watchdog_instr,
	input wire logic clear_watchdog_first,
	input wire logic clear_watchdog_second,
	input wire logic halt_instr,
	input wire logic irq_pending,
	input wire logic irq_enabled,
	input wire logic stack_full,
	input wire logic [wake_width-1:0] wake_pins,
	output logic [7:0] watchdog_select_reg,
	output logic timeout_flag,
	output logic powerdown_flag,
	output logic chip_reset,
	output logic warm_reset,
	output logic sys_clk_run,
	output logic cpu_hold,
	output logic take_interrupt,
	output logic osc_out_pin
);
	typedef struct packed {
		wdt_pkg::power_state_t st;
		logic [7:0] sel;
		logic to;
		logic pd;
		logic [wdt_pkg::base_stages-1:0] base_cnt;
		logic [wdt_pkg::presc_stages-1:0] presc_cnt;
		logic [1:0] div;
		logic first_seen;
		logic second_seen;
		logic [10:0] delay_cnt;
		logic [wake_width-1:0] pins_last;
		logic chip_reset;
		logic warm_reset;
		logic take_int;
		logic osc_out;
		logic clk_run;
		logic hold;
	} core_state_t;
	core_state_t cur;
	core_state_t nxt;
	logic osc_tick;
	logic instr_tick;
	logic wdt_tick;
	logic clr_req;
	logic overflow;
	logic [wake_width-1:0] pin_fall;
	logic presc_hit;
	logic [7:0] presc_mask;

	////////////////////////////////////////////////////////////////////////
	// oscillator ticks cross into the system domain before anything uses them
	wdt_tick_sync #(.stages(wdt_pkg::sync_stages)) u_osc_sync (
		.clk(clk),
		.rst_n(rst_n),
		.level_in(wdt_osc),
		.rise(osc_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// tick selection, clear decode and overflow detection
	always_comb begin
		// instruction clock exists only while the system clock runs
		instr_tick = (cur.div == wdt_pkg::sys_div_last) && (cur.st != wdt_pkg::halt_st);
		wdt_tick = opt_wdt_enable && (opt_wdt_use_rc ? osc_tick : instr_tick);
		// paired mode: second half may arrive in same cycle as the first
		if (opt_two_clear) begin
			clr_req = (cur.first_seen | clear_watchdog_first)
				& (cur.second_seen | clear_watchdog_second);
		end else begin
			clr_req = clear_watchdog_instr;
		end
		clr_req = clr_req & opt_wdt_enable & (cur.st == wdt_pkg::run_st);
		// prescaler output: ratio 2**sel[2:0], code 0 passes every base overflow
		presc_mask = (8'h01 << cur.sel[2:0]) - 8'h01;
		presc_hit = ((cur.presc_cnt & presc_mask[wdt_pkg::presc_stages-1:0])
			== presc_mask[wdt_pkg::presc_stages-1:0]);
		overflow = wdt_tick && (&cur.base_cnt) && presc_hit;
		pin_fall = cur.pins_last & ~wake_pins & opt_wake_enable;
	end

	////////////////////////////////////////////////////////////////////////
	// main next-state logic
	always_comb begin
		nxt = cur;
		nxt.chip_reset = 1'b0;
		nxt.warm_reset = 1'b0;
		nxt.take_int = 1'b0;
		nxt.pins_last = wake_pins;
		nxt.div = cur.div + 2'h1;
		// osc out toggles at twice the instruction rate: sysclk/4 square wave
		if (!opt_crystal && cur.st != wdt_pkg::halt_st && cur.div[0]) begin
			nxt.osc_out = ~cur.osc_out;
		end
		if (opt_crystal) begin
			nxt.osc_out = 1'b0;
		end
		// watchdog count; base stage then prescaler stage
		if (wdt_tick) begin
			nxt.base_cnt = cur.base_cnt + 8'h01;
			if (&cur.base_cnt) begin
				nxt.presc_cnt = presc_hit ? '0 : cur.presc_cnt + 7'h01;
			end
		end
		// software register write: only the select register lives here
		if (reg_write && reg_addr == wdt_pkg::select_reg_offset && cur.st == wdt_pkg::run_st) begin
			nxt.sel = reg_wdata;
		end
		// paired clear bookkeeping
		if (opt_two_clear && opt_wdt_enable) begin
			if (clear_watchdog_first) nxt.first_seen = 1'b1;
			if (clear_watchdog_second) nxt.second_seen = 1'b1;
		end
		if (clr_req) begin
			nxt.base_cnt = '0;
			nxt.presc_cnt = '0;
			nxt.first_seen = 1'b0;
			nxt.second_seen = 1'b0;
			nxt.to = 1'b0;
			nxt.pd = 1'b0;
		end
		case (cur.st)
			wdt_pkg::run_st: begin
				if (!reset_pin_n) begin
					// pin reset in run: flags stay, no startup delay
					nxt.chip_reset = 1'b1;
					nxt.base_cnt = '0;
					nxt.presc_cnt = '0;
					nxt.sel = wdt_pkg::select_reset;
				end else if (overflow) begin
					nxt.chip_reset = 1'b1;
					nxt.to = 1'b1;
					nxt.sel = wdt_pkg::select_reset;
					nxt.base_cnt = '0;
					nxt.presc_cnt = '0;
				end else if (halt_instr) begin
					nxt.st = wdt_pkg::halt_st;
					nxt.pd = 1'b1;
					nxt.to = 1'b0;
					nxt.base_cnt = '0;
					nxt.presc_cnt = '0;
					nxt.first_seen = 1'b0;
					nxt.second_seen = 1'b0;
				end
			end
			wdt_pkg::halt_st: begin
				if (!reset_pin_n) begin
					// full init, cause reads as pin wake
					nxt.chip_reset = 1'b1;
					nxt.to = 1'b0;
					nxt.pd = 1'b1;
					nxt.sel = wdt_pkg::select_reset;
					nxt.base_cnt = '0;
					nxt.presc_cnt = '0;
					nxt.st = wdt_pkg::run_st;
				end else if (overflow) begin
					nxt.warm_reset = 1'b1;
					nxt.to = 1'b1;
					nxt.base_cnt = '0;
					nxt.presc_cnt = '0;
					nxt.st = opt_crystal ? wdt_pkg::delay_st : wdt_pkg::run_st;
					nxt.delay_cnt = '0;
				end else if (irq_pending || (|pin_fall)) begin
					nxt.take_int = irq_pending && irq_enabled && !stack_full;
					nxt.st = opt_crystal ? wdt_pkg::delay_st : wdt_pkg::run_st;
					nxt.delay_cnt = '0;
				end
			end
			wdt_pkg::delay_st: begin
				// dummy period before resuming; pin reset still cuts in
				nxt.delay_cnt = cur.delay_cnt + 11'h001;
				if (!reset_pin_n) begin
					nxt.chip_reset = 1'b1;
					nxt.st = wdt_pkg::run_st;
				end else if (cur.delay_cnt == wdt_pkg::startup_last) begin
					nxt.st = wdt_pkg::run_st;
				end
			end
			default: nxt.st = wdt_pkg::run_st;
		endcase
		// decoded from the coming state so both pins leave straight from flops
		nxt.clk_run = (nxt.st != wdt_pkg::halt_st);
		nxt.hold = (nxt.st != wdt_pkg::run_st);
	end

	////////////////////////////////////////////////////////////////////////
	// state register; power-up lands in the startup delay with flags 00
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cur.st <= wdt_pkg::delay_st;
			cur.sel <= wdt_pkg::select_reset;
			cur.pins_last <= '1;
			cur.chip_reset <= 1'b1;
			cur.clk_run <= 1'b1;
			cur.hold <= 1'b1;
		end else begin
			cur <= nxt;
		end
	end

	// outputs are flip-flop fields
	assign watchdog_select_reg = cur.sel;
	assign timeout_flag = cur.to;
	assign powerdown_flag = cur.pd;
	assign chip_reset = cur.chip_reset;
	assign warm_reset = cur.warm_reset;
	assign sys_clk_run = cur.clk_run;
	assign cpu_hold = cur.hold;
	assign take_interrupt = cur.take_int;
	assign osc_out_pin = cur.osc_out;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_halt_flags;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::run_st && reset_pin_n && !overflow && halt_instr)
			|=> (powerdown_flag && !timeout_flag && cur.st == wdt_pkg::halt_st);
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

	property p_run_overflow;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::run_st && reset_pin_n && overflow) |=> (chip_reset && timeout_flag);
	endproperty
	a_run_overflow: assert property (p_run_overflow) else $error("no reset on overflow");

	property p_halt_overflow;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::halt_st && reset_pin_n && overflow)
			|=> (warm_reset && !chip_reset && timeout_flag && powerdown_flag);
	endproperty
	a_halt_overflow: assert property (p_halt_overflow) else $error("bad warm wake");

	property p_disabled;
		@(posedge clk) disable iff (!rst_n)
		!opt_wdt_enable |-> !overflow && !clr_req;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled watchdog acted");

	property p_flags_stable;
		@(posedge clk) disable iff (!rst_n)
		(!clr_req && !halt_instr && !overflow && reset_pin_n && cur.st == wdt_pkg::run_st)
			|=> $stable(timeout_flag) && $stable(powerdown_flag);
	endproperty
	a_flags_stable: assert property (p_flags_stable) else $error("flags moved");

	property p_instr_halt;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::halt_st && !opt_wdt_use_rc) |-> !wdt_tick && cur.base_cnt == '0;
	endproperty
	a_instr_halt: assert property (p_instr_halt) else $error("instr clock in halt");

	property p_rc_wake;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::halt_st && !opt_crystal && reset_pin_n && (|pin_fall))
			|=> cur.st == wdt_pkg::run_st;
	endproperty
	a_rc_wake: assert property (p_rc_wake) else $error("rc wake delayed");

	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		clr_req |=> !timeout_flag && !powerdown_flag && cur.base_cnt == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	// select write, reset-cause and wake checks
	property p_sel_write;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && reg_addr == wdt_pkg::select_reg_offset && cur.st == wdt_pkg::run_st
			&& reset_pin_n && !overflow) |=> watchdog_select_reg == $past(reg_wdata);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select write lost");

	property p_pin_reset_run;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::run_st && !reset_pin_n && !clr_req)
			|=> chip_reset && !cpu_hold && $stable(timeout_flag) && $stable(powerdown_flag)
			&& watchdog_select_reg == wdt_pkg::select_reset;
	endproperty
	a_pin_reset_run: assert property (p_pin_reset_run) else $error("bad pin reset");

	property p_halt_pin_reset;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::halt_st && !reset_pin_n)
			|=> chip_reset && !cpu_hold && !timeout_flag && powerdown_flag;
	endproperty
	a_halt_pin_reset: assert property (p_halt_pin_reset) else $error("bad halt reset");

	property p_irq_wake;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::halt_st && reset_pin_n && !overflow && irq_pending && irq_enabled
			&& !stack_full) |=> take_interrupt;
	endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("interrupt not taken");

	property p_warm_keeps_sel;
		@(posedge clk) disable iff (!rst_n)
		(cur.st == wdt_pkg::halt_st && reset_pin_n && overflow)
			|=> $stable(watchdog_select_reg);
	endproperty
	a_warm_keeps_sel: assert property (p_warm_keeps_sel) else $error("select moved");

	c_halt: cover property (@(posedge clk) disable iff (!rst_n) cur.st == wdt_pkg::halt_st);
	c_warm: cover property (@(posedge clk) disable iff (!rst_n) warm_reset);
	c_delay_done: cover property (@(posedge clk) disable iff (!rst_n)
		cur.st == wdt_pkg::delay_st ##1 cur.st == wdt_pkg::run_st);
	c_irq_take: cover property (@(posedge clk) disable iff (!rst_n) take_interrupt);
	c_halt_pin: cover property (@(posedge clk) disable iff (!rst_n)
		cur.st == wdt_pkg::halt_st && !reset_pin_n);
endmodule // wdt_halt_reset
`default_nettype wire

// ===== wdt_halt_reset_tb.sv
// file: self-checking bench for the watchdog, halt and reset-cause block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end
`define WAIT(c, lim) begin n = 0; while (!(c) && n < (lim)) begin @(posedge clk); #1; n++; end `CHK(n < (lim), 1'b1) end
module wdt_halt_reset_tb;
	localparam int osc_half = 4; // watchdog oscillator half period, in system clocks
	logic clk, rst_n, reset_pin_n, wdt_osc, reg_write, irq_pending, irq_enabled, stack_full;
	logic serve, want_halt, clr_i, halt_i, took, to_f, pd_f, chip_reset, warm_reset;
	logic run_o, cpu_hold, take_int, osc_out, b, wdt_en, use_rc;
	logic [7:0] reg_addr, reg_wdata, exp_sel, sel;
	logic [11:0] wake_pins, wake_en;
	int miscompares = 0, checks_done = 0, n, r, ovf, resets = 0, ow = 0;
	wdt_halt_reset u_wdt_halt_reset (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
		.wdt_osc(wdt_osc), .opt_wdt_enable(wdt_en), .opt_wdt_use_rc(use_rc), .opt_two_clear(1'b0),
		.opt_crystal(1'b0), .opt_wake_enable(wake_en), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .clear_watchdog_instr(clr_i),
		.clear_watchdog_first(1'b0), .clear_watchdog_second(1'b0), .halt_instr(halt_i),
		.irq_pending(irq_pending), .irq_enabled(irq_enabled), .stack_full(stack_full),
		.wake_pins(wake_pins), .watchdog_select_reg(sel), .timeout_flag(to_f),
		.powerdown_flag(pd_f), .chip_reset(chip_reset), .warm_reset(warm_reset),
		.sys_clk_run(run_o), .cpu_hold(cpu_hold), .take_interrupt(take_int),
		.osc_out_pin(osc_out));
	wdt_cpu_model u_wdt_cpu_model (.clk(clk), .cpu_hold(cpu_hold), .serve(serve),
		.want_halt(want_halt), .clear_watchdog_instr(clr_i), .halt_instr(halt_i));
	////////////////////////////////////////////////////////////////
	// expected overflow time: base divide by 256, then prescale 2**s
	function automatic int ovf_clks(input logic [2:0] s);
		return 256 * (1 << s) * 2 * osc_half;
	endfunction
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// watchdog oscillator and event monitors
	always @(posedge clk) begin
		ow <= (ow == osc_half - 1) ? 0 : ow + 1;
		if (ow == osc_half - 1)
			wdt_osc <= ~wdt_osc;
		if (chip_reset && rst_n)
			resets++;
		if (take_int)
			took <= 1'b1;
	end
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic do_halt();
		@(posedge clk);
		want_halt <= 1'b1;
		@(posedge clk);
		want_halt <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// cut a hang short; about one and a half times the longest run
	initial begin
		#300000;
		miscompares++;
		give_verdict();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, reg_write, irq_pending, irq_enabled, stack_full, serve, want_halt} = 7'h00;
		{reset_pin_n, wdt_osc, took, reg_addr, reg_wdata} = 19'h00000;
		reset_pin_n = 1'b1;
		{wdt_en, use_rc} = 2'h3;
		wake_pins = 12'hFFF;
		wake_en = 12'hFFF;
		void'($urandom(14));
		exp_sel = $urandom;
		exp_sel[2:0] = 3'($urandom % 3); // short prescale keeps the run brief
		ovf = ovf_clks(exp_sel[2:0]);
		@(posedge clk);
		#1;
		`CHK(chip_reset, 1'b1)
		@(posedge clk);
		rst_n <= 1'b1;
		`WAIT(!cpu_hold, 1100)
		`CHK(n >= 1020, 1'b1)
		`CHK(sel, 8'h07)
		`CHK({to_f, pd_f}, 2'h0)
		wr(8'h09, exp_sel);
		`CHK(sel, exp_sel)
		wr(8'h0A, ~exp_sel);
		`CHK(sel, exp_sel)
		`CHK({to_f, pd_f}, 2'h0)
		n = 0;
		repeat (8) begin
			b = osc_out;
			@(posedge clk);
			#1;
			n += (osc_out !== b);
		end
		`CHK(n, 4)
		// halt then wake on a random enabled port pin
		do_halt();
		`CHK({to_f, pd_f, run_o}, 3'h2)
		@(posedge clk);
		wake_pins[$urandom % 12] <= 1'b0;
		`WAIT(!cpu_hold, 8)
		@(posedge clk);
		wake_pins <= 12'hFFF;
		r = resets;
		serve <= 1'b1;
		repeat (2 * ovf) @(posedge clk);
		#1;
		`CHK(resets, r)
		`CHK({to_f, pd_f}, 2'h0)
		serve <= 1'b0;
		// interrupt wake, all enable and stack combinations
		for (int i = 0; i < 4; i++) begin
			do_halt();
			took = 1'b0;
			@(posedge clk);
			irq_enabled <= i[0];
			stack_full <= i[1];
			irq_pending <= 1'b1;
			`WAIT(!cpu_hold, 8)
			@(posedge clk);
			irq_pending <= 1'b0;
			repeat (2) @(posedge clk);
			#1;
			`CHK(took, i[0] & !i[1])
		end
		// overflow while halted gives a warm reset only
		r = resets;
		do_halt();
		`WAIT(warm_reset === 1'b1, ovf + 60)
		`CHK(n >= ovf - 60, 1'b1)
		repeat (2) @(posedge clk);
		#1;
		`CHK({to_f, pd_f}, 2'h3)
		`CHK(sel, exp_sel)
		`CHK(resets, r)
		// pin reset in run, then overflow in run
		@(posedge clk);
		reset_pin_n <= 1'b0;
		@(posedge clk);
		reset_pin_n <= 1'b1;
		@(posedge clk);
		#1;
		`WAIT(!cpu_hold, 4)
		`CHK(resets > r, 1'b1)
		`CHK({to_f, pd_f, sel}, {2'h3, 8'h07})
		wr(8'h09, exp_sel);
		`WAIT(chip_reset === 1'b1, ovf + 60)
		`CHK(n >= ovf - 60, 1'b1)
		repeat (2) @(posedge clk);
		#1;
		`CHK({to_f, pd_f, sel}, {2'h3, 8'h07})
		// disabled watchdog: clears and overflows alike do nothing
		r = resets;
		wdt_en <= 1'b0;
		serve <= 1'b1;
		repeat (ovf + 100) @(posedge clk);
		#1;
		`CHK({resets == r, to_f, pd_f}, 3'h7)
		// instruction clock stands still in halt; a pin reset there is a full init
		serve <= 1'b0;
		wdt_en <= 1'b1;
		use_rc <= 1'b0;
		do_halt();
		repeat (ovf / 2 + 100) @(posedge clk);
		#1;
		`CHK({to_f, pd_f, run_o}, 3'h2)
		r = resets;
		@(posedge clk);
		reset_pin_n <= 1'b0;
		@(posedge clk);
		reset_pin_n <= 1'b1;
		@(posedge clk);
		#1;
		`CHK({resets > r, to_f, pd_f, cpu_hold, sel}, {4'hA, 8'h07})
		wr(8'h09, exp_sel);
		`WAIT(chip_reset === 1'b1, ovf / 2 + 60)
		`CHK(n >= ovf / 2 - 60, 1'b1)
		give_verdict();
	end
endmodule // wdt_halt_reset_tb
`default_nettype wire

// ===== wdt_pkg.sv
// package: constants and types for the watchdog, halt and reset-cause block
package wdt_pkg;
	localparam logic [7:0] select_reg_offset = 8'h09;
	localparam logic [7:0] select_reset = 8'h07;
	localparam int base_stages = 8;
	localparam int presc_stages = 7;
	localparam int sys_div = 4;
	localparam logic [1:0] sys_div_last = 2'h3;
	localparam int startup_clocks = 1024;
	localparam logic [10:0] startup_last = 11'h3FF;
	localparam int wake_pins = 12;
	localparam logic [11:0] pc_reset = 12'h000;
	localparam int sync_stages = 2;
	typedef enum logic [1:0] {
		run_st,
		halt_st,
		delay_st
	} power_state_t;
endpackage

// ===== wdt_tick_sync.sv
// module: event synchroniser carrying one-cycle ticks from the watchdog oscillator input
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_sync #(
	parameter int stages = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic level_in,
	output logic rise
);
	typedef struct packed {
		logic [stages-1:0] pipe;
		logic last;
		logic rise;
	} sync_state_t;
	sync_state_t cur;
	sync_state_t nxt;

	// only the last stage is looked at; the first stage feeds the second alone
	always_comb begin
		nxt = cur;
		nxt.pipe = {cur.pipe[stages-2:0], level_in};
		nxt.last = cur.pipe[stages-1];
		nxt.rise = cur.pipe[stages-1] & ~cur.last;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign rise = cur.rise;
endmodule // wdt_tick_sync
`default_nettype wire
